// File: lcc_pkg.sv
package lcc_pkg;

   localparam int         LCC_NUM_CELLS    = 8;
   localparam int         LCC_ADD_BITS     = 7;
   localparam int         LCC_NUM_DED      = 6;
   localparam int         LCC_ADDR_W       = 8;
   localparam int         LCC_DATA_W       = 32;

   localparam logic [7:0] LCC_REG_MODE     = 8'h00;
   localparam logic [7:0] LCC_REG_GSEL     = 8'h04;
   localparam logic [7:0] LCC_REG_STAT     = 8'h08;

   localparam int         LCC_MODE_LSB     = 0;
   localparam int         LCC_REGUSE_BIT   = 2;
   localparam int         LCC_ACFG_LSB     = 3;
   localparam int         LCC_CLRSEL_BIT   = 6;

   localparam int         LCC_GSEL_CLR_LSB = 0;
   localparam int         LCC_GSEL_PRE_LSB = 3;
   localparam int         LCC_GSEL_ENA_LSB = 6;
   localparam int         LCC_GSEL_OE_LSB  = 9;

   localparam int         LCC_STAT_Q_LSB   = 0;
   localparam int         LCC_STAT_CY_BIT  = 8;
   localparam int         LCC_STAT_BUS_BIT = 9;
   localparam int         LCC_STAT_DED_LSB = 10;

   localparam logic [2:0] LCC_DED_LIMIT    = 3'h6;
   localparam logic [2:0] LCC_GSEL_NONE    = 3'h7;

   localparam logic [31:0] LCC_MODE_RST    = 32'h00000000;
   localparam logic [31:0] LCC_GSEL_RST    = 32'h00000FFF;

   typedef enum logic [1:0] {
      LCC_MODE_ADD = 2'h0,
      LCC_MODE_CNT = 2'h1,
      LCC_MODE_BUS = 2'h2
   } lcc_mode_type;

   typedef enum logic [2:0] {
      LCC_ACFG_CLR      = 3'h0,
      LCC_ACFG_PRE      = 3'h1,
      LCC_ACFG_CLR_PRE  = 3'h2,
      LCC_ACFG_LOAD_CLR = 3'h3,
      LCC_ACFG_LOAD_PRE = 3'h4,
      LCC_ACFG_LOAD     = 3'h5
   } lcc_acfg_type;

endpackage

// File: lcc_cell.sv
`timescale 1ns/10ps
module lcc_cell (
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   input  wire lcc_pkg::lcc_mode_type mode_i,
   input  wire logic              reg_use_i,
   input  wire logic              opa_i,
   input  wire logic              opb_i,
   input  wire logic              cin_i,
   input  wire logic              load_d_i,
   input  wire logic              sync_load_i,
   input  wire logic              sync_clr_b_i,
   input  wire logic              clr_b_i,
   input  wire logic              pre_b_i,
   input  wire logic              aload_b_i,
   input  wire logic              ena_i,
   output logic                   q_o,
   output logic                   sum_o,
   output logic                   cout_o
);
   import lcc_pkg::*;

   logic opb_eff;
   logic add_sum;
   logic add_cy;
   logic cnt_bit;
   logic cnt_cy;
   logic cnt_sel;
   logic next_d;

   // Feeding the register back in place of one operand is what makes it
   // an accumulator rather than a pipelined adder.
   assign opb_eff = reg_use_i ? q_o : opb_i;
   assign add_sum = opa_i ^ opb_eff ^ cin_i;
   assign add_cy  = (opa_i & opb_eff)
                  | (cin_i & (opa_i ^ opb_eff));

   // Two two-input lookup functions: count bit and fast carry.
   assign cnt_bit = q_o ^ cin_i;
   assign cnt_cy  = q_o & cin_i;

   assign cnt_sel = sync_load_i ? load_d_i : cnt_bit;

   always_comb begin
      if (mode_i == LCC_MODE_CNT) begin
         next_d = cnt_sel & sync_clr_b_i;
         sum_o  = cnt_bit;
         cout_o = cnt_cy;
      end else begin
         next_d = add_sum;
         sum_o  = add_sum;
         cout_o = add_cy;
      end
   end

   // Clear wins over preset and load so the state is never ambiguous.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q_o <= 1'b0;
      end else if (!clr_b_i) begin
         q_o <= 1'b0;
      end else if (!pre_b_i) begin
         q_o <= 1'b1;
      end else if (!aload_b_i) begin
         q_o <= load_d_i;
      end else if (ena_i) begin
         q_o <= next_d;
      end
   end

endmodule

// File: lcc_cluster.sv
`timescale 1ns/10ps
module lcc_cluster (
   input  wire logic                          CLK_I,
   input  wire logic                          RST_B_I,
   input  wire logic [lcc_pkg::LCC_ADDR_W-1:0] ADDR_I,
   input  wire logic [lcc_pkg::LCC_DATA_W-1:0] WDATA_I,
   input  wire logic                          WR_I,
   input  wire logic                          RD_I,
   output logic      [lcc_pkg::LCC_DATA_W-1:0] RDATA_O,
   input  wire logic [lcc_pkg::LCC_NUM_DED-1:0] DED_I,
   input  wire logic [lcc_pkg::LCC_NUM_CELLS-1:0] OPA_I,
   input  wire logic [lcc_pkg::LCC_NUM_CELLS-1:0] OPB_I,
   input  wire logic                          CARRY_IN_I,
   input  wire logic [lcc_pkg::LCC_NUM_CELLS-1:0] LOOKUP_DATA_IN_D_I,
   input  wire logic                          SYNC_LOAD_I,
   input  wire logic                          SYNC_CLR_B_I,
   input  wire logic                          CLUSTER_CTL_A_B_I,
   input  wire logic                          CLUSTER_CTL_B_B_I,
   input  wire logic [lcc_pkg::LCC_NUM_CELLS-1:0] BUS_DRV_I,
   input  wire logic [lcc_pkg::LCC_NUM_CELLS-1:0] BUS_OE_I,
   output logic      [lcc_pkg::LCC_NUM_CELLS-1:0] Q_O,
   output logic      [lcc_pkg::LCC_NUM_CELLS-1:0] DATA_O,
   output logic                               CARRY_O,
   output logic                               BUS_O,
   output logic                               OE_O
);
   import lcc_pkg::*;

   lcc_mode_type mode;
   logic         reg_use;
   lcc_acfg_type acfg;
   logic         clr_sel;
   logic [2:0]   gsel_clr;
   logic [2:0]   gsel_pre;
   logic [2:0]   gsel_ena;
   logic [2:0]   gsel_oe;

   logic [LCC_NUM_DED-1:0]   ded_meta;
   logic [LCC_NUM_DED-1:0]   ded_sync;

   logic                     g_clr_b;
   logic                     g_pre_b;
   logic                     g_ena;
   logic                     g_oe;
   logic                     ln_clr_b;
   logic                     ln_pre_b;
   logic                     ln_aload_b;
   logic                     cell_clr_b;
   logic                     cell_pre_b;
   logic                     cell_aload_b;
   logic                     sel_line_b;
   logic                     oth_line_b;

   logic [LCC_NUM_CELLS:0]   carry;
   logic [LCC_NUM_CELLS-1:0] cell_sum;
   logic                     bus_any;
   logic                     bus_multi;
   logic                     next_bus;
   logic [LCC_NUM_CELLS-1:0] add_ref;

   function automatic logic pick_ded(input logic [2:0] sel,
                                     input logic [LCC_NUM_DED-1:0] ded);
      logic r;
      r = 1'b1;
      if (sel < LCC_DED_LIMIT) begin
         r = ded[sel];
      end
      return r;
   endfunction

   // Configuration writes; reads have no side effects.
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         mode    <= lcc_mode_type'(LCC_MODE_RST[LCC_MODE_LSB +: 2]);
         reg_use <= LCC_MODE_RST[LCC_REGUSE_BIT];
         acfg    <= lcc_acfg_type'(LCC_MODE_RST[LCC_ACFG_LSB +: 3]);
         clr_sel <= LCC_MODE_RST[LCC_CLRSEL_BIT];
      end else if (WR_I && (ADDR_I == LCC_REG_MODE)) begin
         mode    <= lcc_mode_type'(WDATA_I[LCC_MODE_LSB +: 2]);
         reg_use <= WDATA_I[LCC_REGUSE_BIT];
         acfg    <= lcc_acfg_type'(WDATA_I[LCC_ACFG_LSB +: 3]);
         clr_sel <= WDATA_I[LCC_CLRSEL_BIT];
      end
   end

   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         gsel_clr <= LCC_GSEL_RST[LCC_GSEL_CLR_LSB +: 3];
         gsel_pre <= LCC_GSEL_RST[LCC_GSEL_PRE_LSB +: 3];
         gsel_ena <= LCC_GSEL_RST[LCC_GSEL_ENA_LSB +: 3];
         gsel_oe  <= LCC_GSEL_RST[LCC_GSEL_OE_LSB +: 3];
      end else if (WR_I && (ADDR_I == LCC_REG_GSEL)) begin
         gsel_clr <= WDATA_I[LCC_GSEL_CLR_LSB +: 3];
         gsel_pre <= WDATA_I[LCC_GSEL_PRE_LSB +: 3];
         gsel_ena <= WDATA_I[LCC_GSEL_ENA_LSB +: 3];
         gsel_oe  <= WDATA_I[LCC_GSEL_OE_LSB +: 3];
      end
   end

   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         RDATA_O <= 32'h00000000;
      end else if (RD_I) begin
         RDATA_O <= 32'h00000000;
         case (ADDR_I)
            LCC_REG_MODE: begin
               RDATA_O[LCC_MODE_LSB +: 2] <= mode;
               RDATA_O[LCC_REGUSE_BIT]    <= reg_use;
               RDATA_O[LCC_ACFG_LSB +: 3] <= acfg;
               RDATA_O[LCC_CLRSEL_BIT]    <= clr_sel;
            end
            LCC_REG_GSEL: begin
               RDATA_O[LCC_GSEL_CLR_LSB +: 3] <= gsel_clr;
               RDATA_O[LCC_GSEL_PRE_LSB +: 3] <= gsel_pre;
               RDATA_O[LCC_GSEL_ENA_LSB +: 3] <= gsel_ena;
               RDATA_O[LCC_GSEL_OE_LSB +: 3]  <= gsel_oe;
            end
            LCC_REG_STAT: begin
               RDATA_O[LCC_STAT_Q_LSB +: LCC_NUM_CELLS] <= Q_O;
               RDATA_O[LCC_STAT_CY_BIT]                 <= CARRY_O;
               RDATA_O[LCC_STAT_BUS_BIT]                <= BUS_O;
               RDATA_O[LCC_STAT_DED_LSB +: LCC_NUM_DED] <= ded_sync;
            end
            default: begin
               RDATA_O <= 32'h00000000;
            end
         endcase
      end else begin
         RDATA_O <= 32'h00000000;
      end
   end

   // Dedicated inputs are pins, so they are retimed before any use.
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ded_meta <= '1;
         ded_sync <= '1;
      end else begin
         ded_meta <= DED_I;
         ded_sync <= ded_meta;
      end
   end

   // A selector left at none reads high, so an unused global never acts.
   assign g_clr_b = pick_ded(gsel_clr, ded_sync);
   assign g_pre_b = pick_ded(gsel_pre, ded_sync);
   assign g_ena   = pick_ded(gsel_ena, ded_sync);
   assign g_oe    = pick_ded(gsel_oe, ded_sync);

   assign sel_line_b = clr_sel ? CLUSTER_CTL_B_B_I
                               : CLUSTER_CTL_A_B_I;
   assign oth_line_b = clr_sel ? CLUSTER_CTL_A_B_I : CLUSTER_CTL_B_B_I;

   always_comb begin
      ln_clr_b   = 1'b1;
      ln_pre_b   = 1'b1;
      ln_aload_b = 1'b1;
      case (acfg)
         LCC_ACFG_CLR: begin
            ln_clr_b = sel_line_b;
         end
         LCC_ACFG_PRE: begin
            ln_pre_b = sel_line_b;
         end
         LCC_ACFG_CLR_PRE: begin
            ln_clr_b = sel_line_b;
            ln_pre_b = oth_line_b;
         end
         LCC_ACFG_LOAD_CLR: begin
            ln_aload_b = CLUSTER_CTL_A_B_I;
            ln_clr_b   = CLUSTER_CTL_B_B_I;
         end
         LCC_ACFG_LOAD_PRE: begin
            ln_aload_b = CLUSTER_CTL_A_B_I;
            ln_pre_b   = CLUSTER_CTL_B_B_I;
         end
         LCC_ACFG_LOAD: begin
            ln_aload_b = CLUSTER_CTL_A_B_I;
         end
         default: begin
            ln_clr_b   = 1'b1;
            ln_pre_b   = 1'b1;
            ln_aload_b = 1'b1;
         end
      endcase
   end

   assign cell_clr_b   = ln_clr_b & g_clr_b;
   assign cell_pre_b   = ln_pre_b & g_pre_b;
   assign cell_aload_b = ln_aload_b;

   assign carry[0] = CARRY_IN_I;

   // The top cell is the extra one of an n plus one adder: in adding mode
   // its operands are forced low so it captures the final carry alone.
   for (genvar i = 0; i < LCC_NUM_CELLS; i++) begin : g_cell
      logic opa;
      logic opb;
      logic ru;
      if (i == LCC_ADD_BITS) begin : g_top
         assign opa = (mode == LCC_MODE_ADD) ? 1'b0 : OPA_I[i];
         assign opb = (mode == LCC_MODE_ADD) ? 1'b0 : OPB_I[i];
         assign ru  = (mode == LCC_MODE_ADD) ? 1'b0 : reg_use;
      end else begin : g_low
         assign opa = OPA_I[i];
         assign opb = OPB_I[i];
         assign ru  = reg_use;
      end
      lcc_cell u_cell (
         .clk_i        (CLK_I),
         .rst_b_i      (RST_B_I),
         .mode_i       (mode),
         .reg_use_i    (ru),
         .opa_i        (opa),
         .opb_i        (opb),
         .cin_i        (carry[i]),
         .load_d_i     (LOOKUP_DATA_IN_D_I[i]),
         .sync_load_i  (SYNC_LOAD_I),
         .sync_clr_b_i (SYNC_CLR_B_I),
         .clr_b_i      (cell_clr_b),
         .pre_b_i      (cell_pre_b),
         .aload_b_i    (cell_aload_b),
         .ena_i        (g_ena),
         .q_o          (Q_O[i]),
         .sum_o        (cell_sum[i]),
         .cout_o       (carry[i+1])
      );
   end

   // Outputs are registered, so a bypassed sum appears one cycle later.
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         DATA_O  <= '0;
         CARRY_O <= 1'b0;
         OE_O    <= 1'b0;
      end else begin
         if ((mode == LCC_MODE_ADD) && !reg_use) begin
            DATA_O <= cell_sum;
         end else begin
            DATA_O <= Q_O;
         end
         if (mode == LCC_MODE_CNT) begin
            CARRY_O <= carry[LCC_NUM_CELLS];
         end else begin
            CARRY_O <= carry[LCC_ADD_BITS];
         end
         OE_O <= g_oe;
      end
   end

   // More than one enable set is found by clearing the lowest set bit.
   assign bus_any   = |BUS_OE_I;
   assign bus_multi = |(BUS_OE_I & (BUS_OE_I - 8'h01));
   assign next_bus  = !bus_any ? 1'b1 :
                      (bus_multi ? 1'b0 : |(BUS_DRV_I & BUS_OE_I));

   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         BUS_O <= 1'b1;
      end else begin
         BUS_O <= next_bus;
      end
   end

   assign add_ref = {1'b0, OPA_I[LCC_ADD_BITS-1:0]}
                  + {1'b0, OPB_I[LCC_ADD_BITS-1:0]}
                  + {7'h00, CARRY_IN_I};

   property p_bus_float;
      @(posedge CLK_I) disable iff (!RST_B_I)
      (BUS_OE_I == 8'h00) |=> BUS_O;
   endproperty
   a_bus_float: assert property (p_bus_float)
      else $error("Floating bus did not read high.");

   property p_bus_contend;
      @(posedge CLK_I) disable iff (!RST_B_I)
      ($countones(BUS_OE_I) > 1) |=> !BUS_O;
   endproperty
   a_bus_contend: assert property (p_bus_contend)
      else $error("Contending bus did not read low.");

   property p_bus_single;
      @(posedge CLK_I) disable iff (!RST_B_I)
      $onehot(BUS_OE_I) |=> (BUS_O == $past(|(BUS_DRV_I & BUS_OE_I)));
   endproperty
   a_bus_single: assert property (p_bus_single)
      else $error("Single bus driver not passed through.");

   property p_clr_first;
      @(posedge CLK_I) disable iff (!RST_B_I)
      !cell_clr_b |=> (Q_O == 8'h00);
   endproperty
   a_clr_first: assert property (p_clr_first)
      else $error("Clear did not empty the cell registers.");

   property p_preset;
      @(posedge CLK_I) disable iff (!RST_B_I)
      (cell_clr_b && !cell_pre_b) |=> (Q_O == 8'hFF);
   endproperty
   a_preset: assert property (p_preset)
      else $error("Active low preset did not set the registers.");

   property p_aload;
      @(posedge CLK_I) disable iff (!RST_B_I)
      (cell_clr_b && cell_pre_b && !cell_aload_b)
         |=> (Q_O == $past(LOOKUP_DATA_IN_D_I));
   endproperty
   a_aload: assert property (p_aload)
      else $error("Load did not copy the lookup data input.");

   property p_sync_clr;
      @(posedge CLK_I) disable iff (!RST_B_I)
      ((mode == LCC_MODE_CNT) && cell_clr_b && cell_pre_b && cell_aload_b
         && g_ena && !SYNC_CLR_B_I) |=> (Q_O == 8'h00);
   endproperty
   a_sync_clr: assert property (p_sync_clr)
      else $error("Synchronous clear did not empty the counter.");

   property p_sync_load;
      @(posedge CLK_I) disable iff (!RST_B_I)
      ((mode == LCC_MODE_CNT) && cell_clr_b && cell_pre_b && cell_aload_b
         && g_ena && SYNC_CLR_B_I && SYNC_LOAD_I)
         |=> (Q_O == $past(LOOKUP_DATA_IN_D_I));
   endproperty
   a_sync_load: assert property (p_sync_load)
      else $error("Synchronous load value not taken.");

   property p_count;
      @(posedge CLK_I) disable iff (!RST_B_I)
      ((mode == LCC_MODE_CNT) && cell_clr_b && cell_pre_b && cell_aload_b
         && g_ena && SYNC_CLR_B_I && !SYNC_LOAD_I && CARRY_IN_I)
         |=> (Q_O == 8'($past(Q_O) + 8'h01));
   endproperty
   a_count: assert property (p_count)
      else $error("Counter did not step by one.");

   property p_adder;
      @(posedge CLK_I) disable iff (!RST_B_I)
      ((mode == LCC_MODE_ADD) && !reg_use && cell_clr_b && cell_pre_b
         && cell_aload_b && g_ena) |=> (Q_O == $past(add_ref));
   endproperty
   a_adder: assert property (p_adder)
      else $error("Registered adder result or final carry wrong.");

endmodule

// File: lcc_nbr_model.sv
`timescale 1ns/10ps
module lcc_nbr_model (
   input  wire logic       clk_i,
   input  wire logic [5:0] ded_req_i,
   output logic      [5:0] ded_o
);
   // Idle pins sit high so an unused clear or preset never acts.
   initial ded_o = 6'h3F;
   // Pins move just after an edge, like a neighbouring register.
   always @(posedge clk_i) begin
      ded_o <= ded_req_i;
   end
endmodule

// File: lcc_cluster_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module lcc_cluster_tb;
   import lcc_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b, wr, rd, cin, sload, sclr_b, cta_b, ctb_b, cy, bus, oe;
   logic [7:0]  addr, opa, opb, ldata, bdrv, boe, q, dout;
   logic [31:0] wdata, rdata, rv;
   logic [5:0]  dreq, ded;
   logic [7:0]  exp_q [18] = '{8'h00, 8'h2A, 8'h00, 8'hFF, 8'h2A, 8'hFF,
      8'h00, 8'hFF, 8'h00, 8'hC3, 8'h00, 8'h00, 8'hC3, 8'hFF, 8'hFF,
      8'hC3, 8'h2A, 8'hC3};
   logic [7:0]  bus_oe [5] = '{8'h00, 8'h81, 8'h04, 8'h80, 8'h08};
   logic [7:0]  bus_dv [5] = '{8'h00, 8'hFF, 8'hFB, 8'h80, 8'h08};
   logic        bus_ex [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
   int          err_count = 0;
   int          checked = 0;
   int          cyc = 0;

   always #5 clk = ~clk;

   lcc_nbr_model nbr (.clk_i(clk), .ded_req_i(dreq), .ded_o(ded));

   lcc_cluster dut (
      .CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .DED_I(ded), .OPA_I(opa),
      .OPB_I(opb), .CARRY_IN_I(cin), .LOOKUP_DATA_IN_D_I(ldata),
      .SYNC_LOAD_I(sload), .SYNC_CLR_B_I(sclr_b),
      .CLUSTER_CTL_A_B_I(cta_b), .CLUSTER_CTL_B_B_I(ctb_b),
      .BUS_DRV_I(bdrv), .BUS_OE_I(boe), .Q_O(q), .DATA_O(dout),
      .CARRY_O(cy), .BUS_O(bus), .OE_O(oe));

   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask

   // Pulls line a (bit 0) and line b (bit 1) low for two edges.
   task automatic ctl(input int j, input logic [7:0] e);
      @(posedge clk);
      cta_b <= ~j[0];
      ctb_b <= ~j[1];
      tk(1);
      `CHK(q, e)
      @(posedge clk);
      cta_b <= 1'b1;
      ctb_b <= 1'b1;
      tk(1);
   endtask

   // The model adds one edge, the synchroniser two more and the cell register one.
   task automatic pins(input logic [5:0] v);
      @(posedge clk);
      dreq <= v;
      tk(4);
   endtask

   task automatic results();
      $display("errors %0d of %0d checks", err_count, checked);
      if (err_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         $display("CHECK FAILED t=%0t timeout", $time);
         results();
      end
   end

   initial begin
      {wr, rd, cin, sload, rst_b} = '0;
      {sclr_b, cta_b, ctb_b} = '1;
      {addr, opa, opb, ldata, bdrv, boe} = '0;
      wdata = '0;
      dreq = 6'h3F;
      tk(16);
      `CHK({rdata, q, dout, cy, bus, oe}, {48'h0, 3'b010})
      @(posedge clk);
      rst_b <= 1'b1;
      rreg(LCC_REG_GSEL, rv);
      `CHK(rv, LCC_GSEL_RST)
      tk(1);
      `CHK(rdata, 32'h0)
      wreg(8'h0C, 32'h1);
      rreg(8'h0C, rv);
      `CHK(rv, 32'h0)
      rreg(LCC_REG_MODE, rv);
      `CHK(rv, LCC_MODE_RST)
      `CHK(oe, 1'b1)
      @(posedge clk);
      opa <= 8'h03;
      opb <= 8'h04;
      cin <= 1'b1;
      tk(1);
      `CHK(q, 8'h08)
      `CHK(dout, 8'h08)
      // Bit 7 of each operand must be ignored by the carry cell.
      @(posedge clk);
      opa <= 8'hD5;
      opb <= 8'hAA;
      tk(1);
      `CHK(q, 8'h80)
      `CHK(cy, 1'b1)
      @(posedge clk);
      {opa, opb, cin} <= '0;
      wreg(LCC_REG_MODE, 32'h4);
      @(posedge clk);
      opa <= 8'h05;
      opb <= 8'h33;
      tk(1);
      `CHK(q, 8'h05)
      tk(1);
      `CHK({q, dout}, 16'h0A05)
      @(posedge clk);
      opa   <= 8'h2A;
      opb   <= 8'h00;
      ldata <= 8'hC3;
      for (int i = 0; i < 6; i++) begin
         wreg(LCC_REG_MODE, 32'(i * 8));
         for (int j = 1; j < 4; j++) begin
            ctl(j, exp_q[i * 3 + j - 1]);
         end
      end
      wreg(LCC_REG_MODE, 32'h40);
      rreg(LCC_REG_MODE, rv);
      `CHK(rv, 32'h40)
      ctl(1, 8'h2A);
      ctl(2, 8'h00);
      // A seventh control code must leave both lines without effect.
      wreg(LCC_REG_MODE, 32'h30);
      ctl(3, 8'h2A);
      wreg(LCC_REG_MODE, 32'h0);
      for (int k = 0; k < 6; k++) begin
         wreg(LCC_REG_GSEL, {20'h0, 3'(k), 6'h3F, 3'(k)});
         pins(~(6'h1 << k));
         `CHK({q, oe}, 9'h000)
         rreg(LCC_REG_STAT, rv);
         `CHK(rv[15:10], ~(6'h1 << k))
         pins(6'h3F);
         `CHK({q, oe}, 9'h055)
      end
      wreg(LCC_REG_GSEL, 32'hFEF);
      pins(6'h1F);
      `CHK(q, 8'hFF)
      pins(6'h3F);
      // A held clock enable must still let the clear through.
      wreg(LCC_REG_GSEL, 32'hE3F);
      pins(6'h3E);
      @(posedge clk);
      opa <= 8'h11;
      tk(2);
      `CHK(q, 8'h2A)
      ctl(1, 8'h00);
      pins(6'h3F);
      `CHK(q, 8'h11)
      wreg(LCC_REG_GSEL, LCC_GSEL_RST);
      wreg(LCC_REG_MODE, 32'h1);
      @(posedge clk);
      ldata <= 8'hFE;
      sload <= 1'b1;
      tk(1);
      `CHK(q, 8'hFE)
      @(posedge clk);
      sload <= 1'b0;
      cin   <= 1'b1;
      tk(2);
      `CHK({cy, q}, 9'h100)
      @(posedge clk);
      cin <= 1'b0;
      tk(2);
      `CHK({cy, q, dout}, 17'h00101)
      wreg(LCC_REG_STAT, 32'hFFFF);
      rreg(LCC_REG_STAT, rv);
      `CHK(rv[7:0], 8'h01)
      @(posedge clk);
      sload  <= 1'b1;
      sclr_b <= 1'b0;
      tk(1);
      `CHK(q, 8'h00)
      @(posedge clk);
      sload  <= 1'b0;
      sclr_b <= 1'b1;
      wreg(LCC_REG_MODE, 32'h2);
      for (int b = 0; b < 5; b++) begin
         @(posedge clk);
         boe  <= bus_oe[b];
         bdrv <= bus_dv[b];
         tk(1);
         `CHK(bus, bus_ex[b])
      end
      results();
   end
endmodule
